// File: logic/tcfp_defs.vh
// constants for the transmitter configuration function parser
// assumes inclusion by bare name from the design files
`ifndef TCFP_DEFS_VH
`define TCFP_DEFS_VH

// ----------------------------------------
// function identifier codes
// ----------------------------------------
`define TCFP_TAG_FREQ 8'h01
`define TCFP_TAG_POWER 8'h02
`define TCFP_TAG_PRIV 8'h03
`define TCFP_TAG_CELL 8'h04
`define TCFP_TAG_TRIG 8'h05
`define TCFP_TAG_WIDTH 8'h06
`define TCFP_TAG_SVC 8'h07

// ----------------------------------------
// payload byte positions and flag bit positions
// ----------------------------------------
`define TCFP_IDX_B0 8'h00
`define TCFP_IDX_B1 8'h01
`define TCFP_IDX_B2 8'h02
`define TCFP_FLAG_MSB 7
`define TCFP_FLAG_LSB 0

// ----------------------------------------
// channel width decode, in kHz
// ----------------------------------------
`define TCFP_WCODE_5M 7'h00
`define TCFP_WCODE_1M7 7'h01
`define TCFP_KHZ_5M 16'h1388
`define TCFP_KHZ_1M7 16'h06A4
`define TCFP_KHZ_NONE 16'h0000

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCFP_OFF_CTRL 8'h00
`define TCFP_OFF_STATUS 8'h04
`define TCFP_OFF_FREQ 8'h08
`define TCFP_OFF_POWER 8'h0C
`define TCFP_OFF_CELL 8'h10
`define TCFP_OFF_WIDTH 8'h14
`define TCFP_OFF_SVC0 8'h20
`define TCFP_OFF_SVC7 8'h3C

// ----------------------------------------
// register fields, reset values and ahb constants
// ----------------------------------------
`define TCFP_CTRL_RESET 2'h1
`define TCFP_CTRL_EN 0
`define TCFP_CTRL_DROP 1
`define TCFP_HTRANS_NONSEQ 1
`define TCFP_ZERO32 32'h00000000

`endif

// File: logic/tcfp_fifo.v
// byte buffer between the packet inserter stream and the parser
// assumes one clock, writer and reader each honour valid and ready
`timescale 1ns/100ps
`default_nettype none

module tcfp_fifo #(
    parameter W = 9,
    parameter D = 8,
    parameter AW = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire in_valid,
    input wire [W-1:0] in_data,
    output reg in_ready,
    output wire out_valid,
    output wire [W-1:0] out_data,
    input wire out_ready
);

    reg [W-1:0] mem_reg [0:D-1];
    reg [AW-1:0] wptr_reg;
    reg [AW-1:0] rptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    reg [AW:0] count_next;

    // handshakes on both sides
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rptr_reg];

    // occupancy after this cycle
    always @* begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // storage write
    always @(posedge hclk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    // pointers, count and registered ready
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wptr_reg <= {AW{1'b0}};
            rptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
        end else begin
            if (push) begin
                wptr_reg <= (wptr_reg == D - 1) ? {AW{1'b0}} : wptr_reg + 1'b1;
            end
            if (pop) begin
                rptr_reg <= (rptr_reg == D - 1) ? {AW{1'b0}} : rptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready <= (count_next != D[AW:0]);
        end
    end

endmodule
`default_nettype wire

// File: logic/tcfp_top.v
// transmitter configuration function parser with ahb-lite registers
// assumes byte stream from the packet inserter, one clock, one ahb master
// Summary of operation
// - each function opens with an 8-bit identifier, 0x01 to 0x07 handled here
// - an 8-bit byte count follows the identifier and delimits the function
// - 24-bit signed carrier shift in hertz, msb first, drives the frequency output
// - 16-bit unsigned radiated level in 0.1 dB steps drives the level output
// - opaque payload bytes pass out uninterpreted to vendor logic
// - serving-area command holds 16-bit code, deferral flag, seven reserved bits
// - serving-area code applies at once when flag clear, else waits for trigger
// - trigger carries a list of 8-bit identifiers of held functions
// - trigger applies the held parameters of every function it names
// - channel-width byte holds 7-bit code then the deferral flag
// - width code 0 is 5 MHz, 1 is 1.7 MHz, others reserved
// - width applies at once when flag clear, else waits for trigger
// - service list of 8-bit numbers, then deferral flag and seven reserved bits
// - services missing from the active list are discarded
// - service list activates at once when flag clear, else waits for trigger
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tcfp_defs.vh"

module tcfp_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire nip_valid,
    input wire [7:0] nip_data,
    input wire nip_start,
    output wire nip_ready,
    input wire [7:0] svc_query,
    output reg svc_keep,
    output reg [23:0] freq_offset,
    output reg [15:0] effective_radiated_level,
    output reg [15:0] serving_area_code,
    output reg [6:0] channel_width_code,
    output reg [15:0] channel_width_khz,
    output reg priv_valid,
    output reg [7:0] priv_data
);

    // ----------------------------------------
    // parser states
    // ----------------------------------------
    localparam [2:0] ST_TAG = 3'b001;
    localparam [2:0] ST_LEN = 3'b010;
    localparam [2:0] ST_BODY = 3'b100;

    reg [2:0] state_reg;
    reg [7:0] tag_reg;
    reg [7:0] len_reg;
    reg [7:0] idx_reg;
    reg [15:0] shift_reg;
    reg [1:0] ctrl_reg;
    reg [7:0] skip_cnt_reg;
    reg cell_pend_reg;
    reg [15:0] cell_slot_reg;
    reg width_pend_reg;
    reg [6:0] width_slot_reg;
    reg svc_pend_reg;
    reg [255:0] svc_stage_reg;
    reg [255:0] svc_slot_reg;
    reg [255:0] svc_active_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg [31:0] rd_next;
    reg [15:0] khz_next;

    wire fifo_valid;
    wire [8:0] fifo_data;
    wire pop;
    wire [7:0] byte_in;
    wire first;
    wire last;
    wire addr_phase;

    // ----------------------------------------
    // input buffer
    // ----------------------------------------
    // parser stalls while disabled, so the buffer fills and pushes back
    tcfp_fifo #(
        .W(9),
        .D(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) tcfp_fifo_inst (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_valid(nip_valid),
        .in_data({nip_start, nip_data}),
        .in_ready(nip_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(ctrl_reg[`TCFP_CTRL_EN])
    );

    assign pop = fifo_valid & ctrl_reg[`TCFP_CTRL_EN];
    assign byte_in = fifo_data[7:0];
    assign first = fifo_data[8];
    assign last = (idx_reg == len_reg - 1'b1);

    // width code to kHz
    always @* begin
        case (channel_width_code)
            `TCFP_WCODE_5M: khz_next = `TCFP_KHZ_5M;
            `TCFP_WCODE_1M7: khz_next = `TCFP_KHZ_1M7;
            default: khz_next = `TCFP_KHZ_NONE;
        endcase
    end

    // ----------------------------------------
    // function parser
    // ----------------------------------------
    // one byte per cycle; a start-marked byte always resyncs to identifier
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_TAG;
            tag_reg <= 8'h00;
            len_reg <= 8'h00;
            idx_reg <= 8'h00;
            shift_reg <= 16'h0000;
            skip_cnt_reg <= 8'h00;
            cell_pend_reg <= 1'b0;
            cell_slot_reg <= 16'h0000;
            width_pend_reg <= 1'b0;
            width_slot_reg <= 7'h00;
            svc_pend_reg <= 1'b0;
            svc_stage_reg <= {256{1'b0}};
            svc_slot_reg <= {256{1'b0}};
            svc_active_reg <= {256{1'b0}};
            freq_offset <= 24'h000000;
            effective_radiated_level <= 16'h0000;
            serving_area_code <= 16'h0000;
            channel_width_code <= 7'h00;
            channel_width_khz <= `TCFP_KHZ_5M;
            priv_valid <= 1'b0;
            priv_data <= 8'h00;
        end else begin
            priv_valid <= 1'b0;
            channel_width_khz <= khz_next == `TCFP_KHZ_NONE ? channel_width_khz : khz_next;
            if (pop) begin
                if (first || state_reg == ST_TAG) begin
                    tag_reg <= byte_in;
                    state_reg <= ST_LEN;
                end else begin
                    case (state_reg)
                        ST_LEN: begin
                            len_reg <= byte_in;
                            idx_reg <= 8'h00;
                            svc_stage_reg <= {256{1'b0}};
                            state_reg <= (byte_in == 8'h00) ? ST_TAG : ST_BODY;
                            if (tag_reg < `TCFP_TAG_FREQ || tag_reg > `TCFP_TAG_SVC) begin
                                skip_cnt_reg <= skip_cnt_reg + 1'b1;
                            end
                        end
                        ST_BODY: begin
                            idx_reg <= idx_reg + 1'b1;
                            shift_reg <= {shift_reg[7:0], byte_in};
                            if (last) begin
                                state_reg <= ST_TAG;
                            end
                            case (tag_reg)
                                `TCFP_TAG_FREQ: begin
                                    if (idx_reg == `TCFP_IDX_B2) begin
                                        freq_offset <= {shift_reg, byte_in};
                                    end
                                end
                                `TCFP_TAG_POWER: begin
                                    if (idx_reg == `TCFP_IDX_B1) begin
                                        effective_radiated_level <= {shift_reg[7:0], byte_in};
                                    end
                                end
                                `TCFP_TAG_PRIV: begin
                                    priv_valid <= 1'b1;
                                    priv_data <= byte_in;
                                end
                                `TCFP_TAG_CELL: begin
                                    if (idx_reg == `TCFP_IDX_B2) begin
                                        if (byte_in[`TCFP_FLAG_MSB]) begin
                                            cell_slot_reg <= shift_reg;
                                            cell_pend_reg <= 1'b1;
                                        end else begin
                                            serving_area_code <= shift_reg;
                                        end
                                    end
                                end
                                `TCFP_TAG_TRIG: begin
                                    // each listed identifier applies and frees its slot
                                    if (byte_in == `TCFP_TAG_CELL && cell_pend_reg) begin
                                        serving_area_code <= cell_slot_reg;
                                        cell_pend_reg <= 1'b0;
                                    end
                                    if (byte_in == `TCFP_TAG_WIDTH && width_pend_reg) begin
                                        channel_width_code <= width_slot_reg;
                                        width_pend_reg <= 1'b0;
                                    end
                                    if (byte_in == `TCFP_TAG_SVC && svc_pend_reg) begin
                                        svc_active_reg <= svc_slot_reg;
                                        svc_pend_reg <= 1'b0;
                                    end
                                end
                                `TCFP_TAG_WIDTH: begin
                                    if (idx_reg == `TCFP_IDX_B0) begin
                                        if (byte_in[`TCFP_FLAG_LSB]) begin
                                            width_slot_reg <= byte_in[7:1];
                                            width_pend_reg <= 1'b1;
                                        end else begin
                                            channel_width_code <= byte_in[7:1];
                                        end
                                    end
                                end
                                `TCFP_TAG_SVC: begin
                                    if (!last) begin
                                        svc_stage_reg[byte_in] <= 1'b1;
                                    end else if (byte_in[`TCFP_FLAG_MSB]) begin
                                        svc_slot_reg <= svc_stage_reg;
                                        svc_pend_reg <= 1'b1;
                                    end else begin
                                        svc_active_reg <= svc_stage_reg;
                                    end
                                end
                                default: begin
                                    // unknown identifier, bytes counted off only
                                end
                            endcase
                        end
                        default: state_reg <= ST_TAG;
                    endcase
                end
            end
        end
    end

    // service filter lookup for the downstream multiplexer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_keep <= 1'b0;
        end else begin
            svc_keep <= svc_active_reg[svc_query];
        end
    end

    // ----------------------------------------
    // ahb-lite register slave
    // ----------------------------------------
    assign addr_phase = hsel & htrans[`TCFP_HTRANS_NONSEQ] & hready;

    // read mux, sampled in the address phase so data stands in the data phase
    always @* begin
        rd_next = `TCFP_ZERO32;
        case (haddr[7:0])
            `TCFP_OFF_CTRL: rd_next = {30'h0, ctrl_reg};
            `TCFP_OFF_STATUS: rd_next = {16'h0000, skip_cnt_reg, 3'h0, state_reg == ST_TAG,
                (khz_next == `TCFP_KHZ_NONE), svc_pend_reg, width_pend_reg,
                cell_pend_reg};
            `TCFP_OFF_FREQ: rd_next = {{8{freq_offset[23]}}, freq_offset};
            `TCFP_OFF_POWER: rd_next = {16'h0000, effective_radiated_level};
            `TCFP_OFF_CELL: rd_next = {16'h0000, serving_area_code};
            `TCFP_OFF_WIDTH: rd_next = {channel_width_khz, 9'h000, channel_width_code};
            default: begin
                if (haddr[7:0] >= `TCFP_OFF_SVC0 && haddr[7:0] <= `TCFP_OFF_SVC7) begin
                    rd_next = svc_active_reg[{haddr[4:2], 5'h00} +: 32];
                end
            end
        endcase
    end

    // address latch, control write, read data, always ready and okay
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            ctrl_reg <= `TCFP_CTRL_RESET;
            hrdata <= `TCFP_ZERO32;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == `TCFP_OFF_CTRL) begin
                ctrl_reg <= hwdata[1:0];
            end
            if (hready) begin
                wr_pend_reg <= addr_phase & hwrite;
                wr_addr_reg <= haddr[7:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata <= rd_next;
            end
        end
    end

endmodule
`default_nettype wire

// File: sim/tcfp_chk_assertions.sv
// concurrent checks on the parser outputs
// assumes bind onto tcfp_top, one clock hclk, reset hresetn active low
`timescale 1ns/100ps
`default_nettype none

module tcfp_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nip_valid,
    input wire logic nip_ready,
    input wire logic svc_keep,
    input wire logic [23:0] freq_offset,
    input wire logic [15:0] effective_radiated_level,
    input wire logic [15:0] serving_area_code,
    input wire logic [6:0] channel_width_code,
    input wire logic [15:0] channel_width_khz,
    input wire logic priv_valid
);
    logic [15:0] taken_reg;
    logic [15:0] priv_reg;

    // --------------------
    // byte and pulse counters
    // --------------------
    // saturating counts since reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            taken_reg <= 16'h0000;
            priv_reg <= 16'h0000;
        end else begin
            if (nip_valid && nip_ready && taken_reg != 16'hFFFF)
                taken_reg <= taken_reg + 16'h1;
            if (priv_valid && priv_reg != 16'hFFFF)
                priv_reg <= priv_reg + 16'h1;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // --------------------
    // output relations
    // --------------------
    freq_quiet_a: assert property (
        taken_reg < 16'h0005 |-> freq_offset == 24'h000000)
        else $error("carrier shift moved early");
    level_moved_a: assert property (
        $changed(effective_radiated_level) |-> taken_reg >= 16'h0004)
        else $error("level moved early");
    area_moved_a: assert property (
        $changed(serving_area_code) |-> taken_reg >= 16'h0005)
        else $error("area code moved early");
    priv_count_a: assert property (
        priv_valid |-> priv_reg + 16'h0003 <= taken_reg)
        else $error("too many payload pulses");
    code_quiet_a: assert property (
        taken_reg < 16'h0003 |-> channel_width_code == 7'h00)
        else $error("width code moved early");
    width_decode_a: assert property (
        channel_width_khz == 16'h1388 || channel_width_khz == 16'h06A4)
        else $error("width off the defined values");
    width_match_a: assert property (
        $past(channel_width_code) < 7'h02 |->
        channel_width_khz == ($past(channel_width_code) == 7'h00 ? 16'h1388 : 16'h06A4))
        else $error("width does not match code");
    svc_quiet_a: assert property (
        taken_reg < 16'h0004 |=> !svc_keep)
        else $error("service kept too early");
endmodule

bind tcfp_top tcfp_chk tcfp_chk_inst (.hclk, .hresetn, .nip_valid, .nip_ready, .svc_keep,
    .freq_offset, .effective_radiated_level, .serving_area_code, .channel_width_code,
    .channel_width_khz, .priv_valid);

`default_nettype wire

// File: sim/tcfp_src.sv
// model of the upstream packet inserter feeding the byte stream
// assumes the bench fills q with {start, byte} items and sets gap
`timescale 1ns/100ps
`default_nettype none

module tcfp_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic nip_ready,
    output var logic nip_valid,
    output var logic [7:0] nip_data,
    output var logic nip_start
);
    logic [8:0] q[$];
    int gap = 0;
    int wait_cnt;

    // holds a byte until taken; idle data toggles so nothing stale is read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nip_valid <= 1'b0;
            nip_data <= 8'h00;
            nip_start <= 1'b0;
            wait_cnt <= 0;
        end else if (!(nip_valid && !nip_ready)) begin
            if (wait_cnt == 0 && q.size() != 0) begin
                {nip_start, nip_data} <= q.pop_front();
                nip_valid <= 1'b1;
                wait_cnt <= gap;
            end else begin
                nip_valid <= 1'b0;
                nip_start <= 1'b0;
                nip_data <= ~nip_data;
                if (wait_cnt != 0)
                    wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

`default_nettype wire

// File: sim/test_transmitter_config_function_parser.sv
// self-checking bench for the parser
// assumes tcfp_top, the inserter model tcfp_src and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "tcfp_defs.vh"

module test_transmitter_config_function_parser;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] svc_query = 8'h00;
    logic [31:0] rd;
    logic [7:0] priv_q[$];
    int errors = 0;
    int checks_done = 0;
    wire hready, hreadyout, hresp, nip_valid, nip_start, nip_ready, svc_keep, priv_valid;
    wire [31:0] hrdata;
    wire [7:0] nip_data, priv_data;
    wire [23:0] freq_offset;
    wire [15:0] effective_radiated_level, serving_area_code, channel_width_khz;
    wire [6:0] channel_width_code;

    tcfp_top tcfp_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .nip_valid, .nip_data, .nip_start,
        .nip_ready, .svc_query, .svc_keep, .freq_offset, .effective_radiated_level,
        .serving_area_code, .channel_width_code, .channel_width_khz, .priv_valid, .priv_data);
    tcfp_src tcfp_src_inst (.hclk, .hresetn, .nip_ready, .nip_valid, .nip_data, .nip_start);

    // one slave drives bus ready; payload bytes are logged
    assign hready = hreadyout;
    always #12.5 hclk = ~hclk;
    always @(posedge hclk) if (priv_valid === 1'b1) priv_q.push_back(priv_data);

    // --------------------
    // shared tasks
    // --------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // single ahb transfer: each phase held until ready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(posedge hclk);
                n++;
            end while (hready !== 1'b1 && n < 100);
            if (n >= 100) begin
                errors++;
                print_verdict();
            end
            if (p == 0) begin
                htrans <= 2'h0;
                hsel <= 1'b0;
                hwdata <= wd;
            end
        end
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // one function: identifier, count, n payload bytes msb first
    task automatic fn(input logic [7:0] id, input int n, input logic [31:0] p);
        @(negedge hclk);
        tcfp_src_inst.q.push_back({1'b1, id});
        tcfp_src_inst.q.push_back({1'b0, n[7:0]});
        for (int i = n - 1; i >= 0; i--)
            tcfp_src_inst.q.push_back({1'b0, p[8*i +: 8]});
    endtask

    // waits for the inserter, fifo and parser to drain
    task automatic settle;
        int n;
        n = 0;
        while ((tcfp_src_inst.q.size() != 0 || nip_valid !== 1'b0) && n < 500) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 500) begin
            errors++;
            print_verdict();
        end
        repeat (12) @(posedge hclk);
    endtask

    task automatic svc(input logic [7:0] s, input logic exp);
        svc_query <= s;
        repeat (2) @(posedge hclk);
        chk("svc keep", {31'h0, svc_keep}, {31'h0, exp});
    endtask

    // --------------------
    // scenarios
    // --------------------
    task automatic t_reset;
        ahb(1'b0, `TCFP_OFF_CTRL, 32'h0);
        chk("ctrl", rd, 32'h00000001);
        ahb(1'b0, `TCFP_OFF_WIDTH, 32'h0);
        chk("width reg", rd, {`TCFP_KHZ_5M, 16'h0000});
        ahb(1'b0, 8'h80, 32'h0);
        chk("unmapped", rd, 32'h00000000);
    endtask

    task automatic t_direct;
        tcfp_src_inst.gap = 2;
        fn(`TCFP_TAG_FREQ, 3, 32'h00800001);
        fn(`TCFP_TAG_POWER, 2, 32'h0000FFFE);
        settle();
        tcfp_src_inst.gap = 0;
        chk("freq", {8'h00, freq_offset}, 32'h00800001);
        chk("level", {16'h0, effective_radiated_level}, 32'h0000FFFE);
        ahb(1'b0, `TCFP_OFF_FREQ, 32'h0);
        chk("freq reg", rd, 32'hFF800001);
    endtask

    task automatic t_priv;
        logic [23:0] exp_p;
        exp_p = 24'hA55A3C;
        fn(`TCFP_TAG_PRIV, 3, {8'h00, exp_p});
        fn(8'h0B, 2, 32'h00001122);
        fn(`TCFP_TAG_FREQ, 1, 32'h00000011);
        fn(`TCFP_TAG_POWER, 2, 32'h00000064);
        settle();
        chk("priv count", priv_q.size(), 32'd3);
        for (int i = 0; i < 3; i++)
            chk("priv byte", {24'h0, priv_q[i]}, {24'h0, exp_p[8*(2-i) +: 8]});
        chk("level", {16'h0, effective_radiated_level}, 32'h00000064);
        chk("freq kept", {8'h00, freq_offset}, 32'h00800001);
    endtask

    task automatic t_area;
        fn(`TCFP_TAG_CELL, 3, 32'h00123480);
        fn(`TCFP_TAG_CELL, 3, 32'h00567880);
        settle();
        chk("area held", {16'h0, serving_area_code}, 32'h0);
        ahb(1'b0, `TCFP_OFF_STATUS, 32'h0);
        chk("area pending", {31'h0, rd[0]}, 32'h1);
        fn(`TCFP_TAG_TRIG, 1, 32'h00000004);
        settle();
        chk("area applied", {16'h0, serving_area_code}, 32'h00005678);
        fn(`TCFP_TAG_CELL, 3, 32'h00ABCD00);
        fn(`TCFP_TAG_TRIG, 1, 32'h00000004);
        settle();
        chk("area now", {16'h0, serving_area_code}, 32'h0000ABCD);
    endtask

    task automatic t_width;
        fn(`TCFP_TAG_WIDTH, 1, 32'h00000002);
        settle();
        chk("khz", {16'h0, channel_width_khz}, {16'h0, `TCFP_KHZ_1M7});
        chk("code", {25'h0, channel_width_code}, 32'h1);
        fn(`TCFP_TAG_WIDTH, 1, 32'h0000000A);
        fn(`TCFP_TAG_WIDTH, 1, 32'h00000001);
        settle();
        chk("khz held", {16'h0, channel_width_khz}, {16'h0, `TCFP_KHZ_1M7});
        fn(`TCFP_TAG_TRIG, 2, 32'h00000607);
        settle();
        chk("khz applied", {16'h0, channel_width_khz}, {16'h0, `TCFP_KHZ_5M});
        chk("code applied", {25'h0, channel_width_code}, 32'h0);
    endtask

    task automatic t_svc;
        fn(`TCFP_TAG_SVC, 3, 32'h0005FF80);
        settle();
        svc(8'h05, 1'b0);
        fn(`TCFP_TAG_TRIG, 1, 32'h00000007);
        settle();
        svc(8'h05, 1'b1);
        svc(8'hFF, 1'b1);
        svc(8'h06, 1'b0);
        ahb(1'b0, `TCFP_OFF_SVC7, 32'h0);
        chk("svc map", rd, 32'h80000000);
        fn(`TCFP_TAG_SVC, 2, 32'h00000000);
        settle();
        svc(8'h00, 1'b1);
        svc(8'h05, 1'b0);
    endtask

    // parser stopped: buffer fills, refuses, then drains
    task automatic t_fifo;
        ahb(1'b1, `TCFP_OFF_CTRL, 32'h0);
        tcfp_src_inst.gap = 1;
        fn(`TCFP_TAG_FREQ, 3, 32'h0000002A);
        fn(`TCFP_TAG_POWER, 2, 32'h00000007);
        fn(`TCFP_TAG_POWER, 2, 32'h00000008);
        repeat (40) @(posedge hclk);
        chk("ready full", {31'h0, nip_ready}, 32'h0);
        chk("freq stopped", {8'h00, freq_offset}, 32'h00800001);
        ahb(1'b1, `TCFP_OFF_CTRL, 32'h1);
        settle();
        tcfp_src_inst.gap = 0;
        chk("freq", {8'h00, freq_offset}, 32'h0000002A);
        chk("level", {16'h0, effective_radiated_level}, 32'h00000008);
    endtask

    // --------------------
    // main sequence and hang guard
    // --------------------
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        t_reset();
        t_direct();
        t_priv();
        t_area();
        t_width();
        t_svc();
        t_fifo();
        print_verdict();
    end

    initial begin
        repeat (40000) @(posedge hclk);
        errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
